// file: common/dpc_pkg.sv
package dpc_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLK_PERIOD_PS = 8000;
	localparam int SELECT_TO_WRITE_END_NS = 50;
	localparam int WRITE_PULSE_MIN_NS = 50;
	localparam int DRIVE_OFF_DELAY_NS = 20;
	localparam int SELECT_ACCESS_DELAY_NS = 55;
	localparam int ENABLE_ACCESS_DELAY_NS = 20;
	localparam int FLAG_RELEASE_DELAY_NS = 30;
	localparam int FLAG_HIGH_TO_DATA_NS = 55;
	localparam int ARBITRATION_SETUP_NS = 5;
	// Least times round up to whole cycles
	localparam int WR_CYC = (SELECT_TO_WRITE_END_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int OFF_CYC = (DRIVE_OFF_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int RD_CYC = (SELECT_ACCESS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int FLOW_CYC =
		((FLAG_RELEASE_DELAY_NS + FLAG_HIGH_TO_DATA_NS) * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int SET_CYC = (ARBITRATION_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// ==========================================================
	// Geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 9;
	localparam int CNT_W = 5;
	typedef enum logic [2:0] {DPC_IDLE, DPC_SETUP, DPC_WRITE, DPC_RECOVER, DPC_READ} dpc_state_e;
endpackage : dpc_pkg

// file: core/dpc_port_host.sv
`timescale 1ns/1ps
`default_nettype none
module dpc_port_host
	import dpc_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [AW-1:0] req_addr,
	input wire logic [DW-1:0] req_wdata,
	output logic req_ready,
	output logic rsp_valid,
	output logic [DW-1:0] rsp_rdata,
	output logic [AW-1:0] mem_addr,
	output logic mem_sel_n,
	output logic mem_wr_n,
	output logic mem_oe_n,
	input wire logic [DW-1:0] mem_data_in,
	output logic [DW-1:0] mem_data_out,
	output logic mem_data_oe,
	input wire logic mem_busy_n
);
	// ==========================================================
	// Reset release and pin synchronisers
	logic rst_s1, rst_s2;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rst_s1 <= 1'b0;
			rst_s2 <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_s2 <= rst_s1;
		end
	end
	logic [DW-1:0] din_s1, din_s2;
	// flag input wired from the primary flag output
	logic busy_s1, busy_s2;
	always_ff @(posedge clk_sys or negedge rst_s2) begin
		if (!rst_s2) begin
			din_s1 <= '0;
			din_s2 <= '0;
			busy_s1 <= 1'b1;
			busy_s2 <= 1'b1;
		end else begin
			din_s1 <= mem_data_in;
			din_s2 <= din_s1;
			busy_s1 <= mem_busy_n;
			busy_s2 <= busy_s1;
		end
	end
	// ==========================================================
	// Access sequencer
	dpc_state_e state, next_state;
	logic [CNT_W-1:0] cnt, next_cnt;
	logic [AW-1:0] next_mem_addr, last_waddr, next_last_waddr;
	logic [DW-1:0] next_mem_data_out, next_rsp_rdata;
	logic next_sel_n, next_wr_n, next_oe_n, next_data_oe, next_req_ready, next_rsp_valid;
	logic is_wr, next_is_wr, recent_wr, next_recent_wr;
	logic [CNT_W-1:0] flow_cnt, next_flow_cnt;
	// Next-state logic for one pin-level access
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_mem_addr = mem_addr;
		next_mem_data_out = mem_data_out;
		next_sel_n = mem_sel_n;
		next_wr_n = mem_wr_n;
		next_oe_n = mem_oe_n;
		next_data_oe = mem_data_oe;
		next_req_ready = 1'b0;
		next_rsp_valid = 1'b0;
		next_rsp_rdata = rsp_rdata;
		next_is_wr = is_wr;
		next_last_waddr = last_waddr;
		next_recent_wr = recent_wr;
		next_flow_cnt = (flow_cnt != '0) ? flow_cnt - 1'b1 : flow_cnt;
		if (flow_cnt == 5'h01) begin
			next_recent_wr = 1'b0;
		end
		case (state)
			DPC_IDLE: begin
				next_req_ready = 1'b1;
				if (req_valid && req_ready) begin
					next_req_ready = 1'b0;
					next_mem_addr = req_addr;
					next_wr_n = 1'b1;
					next_sel_n = 1'b0;
					next_is_wr = req_write;
					next_mem_data_out = req_wdata;
					// outputs floated by enable before data drive
					next_oe_n = 1'b1;
					next_data_oe = 1'b0;
					next_cnt = CNT_W'(OFF_CYC + SET_CYC);
					next_state = DPC_SETUP;
				end
			end
			DPC_SETUP: begin
				next_cnt = cnt - 1'b1;
				if (cnt == 5'h01) begin
					if (is_wr) begin
						if (busy_s2) begin
							// strobe and select low start the write
							next_wr_n = 1'b0;
							next_data_oe = 1'b1;
							// strobe held low for the pulse minimum
							next_cnt = CNT_W'(WR_CYC);
							next_state = DPC_WRITE;
						end else begin
							next_cnt = cnt;
						end
					end else if (recent_wr && last_waddr == mem_addr) begin
						next_cnt = cnt;
					end else begin
						// select and enable low, strobe high
						next_oe_n = 1'b0;
						next_cnt = CNT_W'(RD_CYC + 2);
						next_state = DPC_READ;
					end
				end
			end
			DPC_WRITE: begin
				next_cnt = cnt - 1'b1;
				if (cnt == 5'h01) begin
					// strobe rises while select stays low
					next_wr_n = 1'b1;
					next_last_waddr = mem_addr;
					next_recent_wr = 1'b1;
					next_flow_cnt = CNT_W'(FLOW_CYC);
					next_state = DPC_RECOVER;
				end
			end
			DPC_RECOVER: begin
				next_data_oe = 1'b0;
				next_sel_n = 1'b1;
				next_rsp_valid = 1'b1;
				next_state = DPC_IDLE;
			end
			DPC_READ: begin
				next_cnt = cnt - 1'b1;
				// sample after the access delay plus sync stages
				if (cnt == 5'h01) begin
					next_rsp_rdata = din_s2;
					next_rsp_valid = 1'b1;
					next_oe_n = 1'b1;
					next_sel_n = 1'b1;
					next_state = DPC_IDLE;
				end
			end
			default: begin
				next_state = DPC_IDLE;
			end
		endcase
	end
	// Sequencer registers
	always_ff @(posedge clk_sys or negedge rst_s2) begin
		if (!rst_s2) begin
			state <= DPC_IDLE;
			cnt <= '0;
			mem_addr <= '0;
			mem_data_out <= '0;
			mem_sel_n <= 1'b1;
			mem_wr_n <= 1'b1;
			mem_oe_n <= 1'b1;
			mem_data_oe <= 1'b0;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			rsp_rdata <= '0;
			is_wr <= 1'b0;
			last_waddr <= '0;
			recent_wr <= 1'b0;
			flow_cnt <= '0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			mem_addr <= next_mem_addr;
			mem_data_out <= next_mem_data_out;
			mem_sel_n <= next_sel_n;
			mem_wr_n <= next_wr_n;
			mem_oe_n <= next_oe_n;
			mem_data_oe <= next_data_oe;
			req_ready <= next_req_ready;
			rsp_valid <= next_rsp_valid;
			rsp_rdata <= next_rsp_rdata;
			is_wr <= next_is_wr;
			last_waddr <= next_last_waddr;
			recent_wr <= next_recent_wr;
			flow_cnt <= next_flow_cnt;
		end
	end
	// ==========================================================
	// Assertions
	// pulse held for the minimum
	wr_pulse_len_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
		$fell(mem_wr_n) |-> !mem_wr_n [*7]) else $error("write pulse too short");
	wr_end_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
		$rose(mem_wr_n) |-> !mem_sel_n) else $error("select high at write end");
	// no data drive while output enabled
	data_drive_oe_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
		mem_data_oe |-> mem_oe_n) else $error("driving while enable low");
	read_strobe_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
		!mem_oe_n |-> mem_wr_n && !mem_sel_n) else $error("bad read pins");
	addr_strobe_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
		!$stable(mem_addr) |-> mem_wr_n) else $error("address moved in write");
	// write starts only with flag high
	wr_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
		$fell(mem_wr_n) |-> $past(busy_s2)) else $error("write during contention");
	read_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
		$fell(mem_oe_n) |-> !mem_oe_n [*8]) else $error("read ended too early");
	// write strobe low only with select low
	wr_sel_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
		!mem_wr_n |-> !mem_sel_n) else $error("strobe without select");
	desel_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_s2)
		mem_sel_n |-> !mem_data_oe && mem_wr_n) else $error("activity while deselected");
	write_cv: cover property (@(posedge clk_sys) disable iff (!rst_s2)
		$rose(mem_wr_n) ##[1:3] rsp_valid);
	read_cv: cover property (@(posedge clk_sys) disable iff (!rst_s2)
		$rose(mem_oe_n) && rsp_valid);
	busy_cv: cover property (@(posedge clk_sys) disable iff (!rst_s2)
		state == DPC_SETUP && is_wr && !busy_s2);
endmodule : dpc_port_host
`default_nettype wire

// file: tb/dpc_sram_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpc_sram_model
	import dpc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic [ADDR_W-1:0] mem_addr,
	input wire logic mem_sel_n,
	input wire logic mem_wr_n,
	input wire logic mem_oe_n,
	input wire logic [DATA_W-1:0] mem_data_out,
	input wire logic mem_data_oe,
	input wire logic busy_hold,
	output logic [DATA_W-1:0] mem_data_in,
	output logic mem_busy_n
);
	localparam int OE_CYC = (ENABLE_ACCESS_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// ==========================================================
	// Array and pins
	logic [DATA_W-1:0] mem [0:4095];
	logic [DATA_W-1:0] last = '0;
	logic [ADDR_W-1:0] wa = '0;
	int cs = 0;
	int co = 0;
	int age = 99;
	logic ok;
	// data valid after both access delays and flow-through
	assign ok = !mem_sel_n && mem_wr_n && !mem_oe_n && cs >= RD_CYC && co >= OE_CYC
		&& !(wa == mem_addr && age < FLOW_CYC);
	// floated pins show a pattern that changes each cycle
	assign mem_data_in = ok ? mem[mem_addr] : ~last;
	// primary flag output; bench holds the settled arbitration outcome
	assign mem_busy_n = ~busy_hold;
	// write while strobe and select low with data driven, output enable ignored
	always @(posedge clk_sys) begin
		cs <= mem_sel_n ? 0 : cs + 1;
		co <= mem_oe_n ? 0 : co + 1;
		age <= (age < 99) ? age + 1 : age;
		last <= mem_data_in;
		if (!mem_sel_n && !mem_wr_n && mem_data_oe) begin
			mem[mem_addr] <= mem_data_out;
			wa <= mem_addr;
			age <= 0;
		end
	end
endmodule : dpc_sram_model
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
	import dpc_pkg::*;
;
	logic clk_sys = 0;
	logic rstn = 0;
	logic req_valid = 0;
	logic req_write = 0;
	logic [ADDR_W-1:0] req_addr = '0;
	logic [DATA_W-1:0] req_wdata = '0;
	logic busy_hold = 0;
	logic req_ready, rsp_valid, mem_sel_n, mem_wr_n, mem_oe_n, mem_data_oe, mem_busy_n;
	logic [DATA_W-1:0] rsp_rdata, mem_data_in, mem_data_out;
	logic [ADDR_W-1:0] mem_addr;
	int errors = 0;
	int n_tests = 0;
	int wr_run = 0;
	// Clock and instances
	always #4 clk_sys = ~clk_sys;
	dpc_port_host dut_u (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.req_valid(req_valid),
		.req_write(req_write),
		.req_addr(req_addr),
		.req_wdata(req_wdata),
		.req_ready(req_ready),
		.rsp_valid(rsp_valid),
		.rsp_rdata(rsp_rdata),
		.mem_addr(mem_addr),
		.mem_sel_n(mem_sel_n),
		.mem_wr_n(mem_wr_n),
		.mem_oe_n(mem_oe_n),
		.mem_data_in(mem_data_in),
		.mem_data_out(mem_data_out),
		.mem_data_oe(mem_data_oe),
		.mem_busy_n(mem_busy_n)
	);
	dpc_sram_model mdl_u (
		.clk_sys(clk_sys),
		.mem_addr(mem_addr),
		.mem_sel_n(mem_sel_n),
		.mem_wr_n(mem_wr_n),
		.mem_oe_n(mem_oe_n),
		.mem_data_out(mem_data_out),
		.mem_data_oe(mem_data_oe),
		.busy_hold(busy_hold),
		.mem_data_in(mem_data_in),
		.mem_busy_n(mem_busy_n)
	);
	// ==========================================================
	// Checks
	task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Strobe pulse length and drive clash on the pins, sampled between edges
	always @(negedge clk_sys) begin
		if (mem_data_oe === 1'b1) chk(DATA_W'(mem_oe_n), 9'h001);
		if (mem_wr_n === 1'b0) wr_run++;
		else if (wr_run > 0) begin
			chk(DATA_W'(wr_run >= WR_CYC), 9'h001);
			wr_run = 0;
		end
	end
	// One request, waits for its answer
	task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 200) begin
			@(negedge clk_sys);
			n++;
		end
		req_valid = 1;
		req_write = w;
		req_addr = a;
		req_wdata = d;
		@(negedge clk_sys);
		req_valid = 0;
		n = 0;
		while (rsp_valid !== 1'b1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		chk(DATA_W'(n < 400), 9'h001);
	endtask : access
	// ==========================================================
	// Scenarios
	task automatic t_rw();
		access(1, 12'h000, 9'h1ff);
		access(1, 12'hfff, 9'h0aa);
		access(0, 12'h000, '0);
		chk(rsp_rdata, 9'h1ff);
		access(0, 12'hfff, '0);
		chk(rsp_rdata, 9'h0aa);
		$display("t_rw done");
	endtask : t_rw
	task automatic t_flow();
		access(1, 12'h5a5, 9'h055);
		access(0, 12'h5a5, '0);
		chk(rsp_rdata, 9'h055);
		access(1, 12'h5a5, 9'h100);
		access(0, 12'h5a5, '0);
		chk(rsp_rdata, 9'h100);
		$display("t_flow done");
	endtask : t_flow
	task automatic t_busy();
		busy_hold = 1;
		fork
			access(1, 12'h123, 9'h0f0);
			begin
				repeat (30) @(negedge clk_sys);
				chk(DATA_W'(mem_wr_n), 9'h001);
				busy_hold = 0;
			end
		join
		access(0, 12'h123, '0);
		chk(rsp_rdata, 9'h0f0);
		$display("t_busy done");
	endtask : t_busy
	// ==========================================================
	// Verdict
	task automatic wrap_up();
		$display("errors=%0d n_tests=%0d", errors, n_tests);
		if (errors == 0 && n_tests > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : wrap_up
	// Main sequence
	initial begin
		repeat (12) @(negedge clk_sys);
		// Pins idle and deselected while reset is held
		chk(DATA_W'({mem_sel_n, mem_wr_n, mem_oe_n, mem_data_oe, req_ready, rsp_valid}), 9'h038);
		rstn = 1;
		t_rw();
		t_flow();
		t_busy();
		wrap_up();
	end
	// Watchdog
	initial begin
		#200000;
		errors++;
		wrap_up();
	end
endmodule : tb
`default_nettype wire
